// [include/adcsc_pkg.sv]
/*
 * adcsc_pkg: constants, field layout and state type for the serial
 * conversion control of the delta-sigma converter.
 * assumes a 50 MHz system clock; the analog side supplies results.
 */
package adcsc_pkg;

	// ==========================================================
	// clock and timing
	localparam int CLK_FREQ_KHZ  = 50000;
	localparam int ISCK_FREQ_KHZ = 900;
	// half period of the internal serial clock, rounded down
	localparam int ISCK_HALF     = CLK_FREQ_KHZ / (2 * ISCK_FREQ_KHZ);
	// internal conversion oscillator as a divider of the system clock
	localparam int OSC_FREQ_KHZ  = 10000;
	localparam int OSC_DIV       = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
	// frequency control counts as tied if no edge in this many cycles
	localparam int FREQ_IDLE     = 255;

	// ==========================================================
	// serial word layout
	localparam int          WORD_BITS    = 32;
	localparam int          CFG_BITS     = 8;
	localparam logic [5:0]  WORD_BITS_6  = 6'h20;
	localparam logic [5:0]  CFG_BITS_6   = 6'h08;
	localparam int          CFG_EN_POS   = 7;
	localparam int          CFG_CH_HI    = 6;
	localparam int          CFG_CH_LO    = 5;
	localparam int          CFG_OSR_HI   = 4;
	localparam int          CFG_OSR_LO   = 1;
	localparam int          CFG_DBL_POS  = 0;

	// ==========================================================
	// reset selection: first differential pair, ratio 256, normal rate
	localparam logic [1:0]  CH_RESET     = 2'h0;
	localparam logic [3:0]  OSR_RESET    = 4'h3;
	localparam logic        DBL_RESET    = 1'b0;
	localparam logic [3:0]  OSR_CODE_MAX = 4'h0A;
	localparam logic [5:0]  OSR_MIN_LOG2 = 6'h05;

	// ==========================================================
	// out-of-range codes for bits 29..0
	localparam logic [29:0] OVER_CODE    = 30'h30000000;
	localparam logic [29:0] UNDER_CODE   = 30'h0FFFFFFF;

	typedef enum logic [1:0] {
		ST_CONV,
		ST_SLEEP,
		ST_OUTPUT
	} adcsc_state_t;

endpackage

// [verilog/adcsc_top.sv]
/*
 * adcsc_top: conversion cycle and serial port control of a
 * delta-sigma converter (conversion, sleep, data output).
 * assumes the analog side presents a settled result with its range
 * flags at the end of each conversion; all pins are asynchronous.
 */
// Notes on behaviour
// - internal clock mode drives serial clock pin; external mode takes it as input
// - clock source select low: host supplies the serial clock
// - clock source select high: device makes and drives its own serial clock
// - busy high while converting, low when the result is ready
// - busy stays low in sleep and output, rises when output ends
// - in internal clock mode low busy frames the shifted-out data
// - serial input word selects speed, rate mode, resolution, channel for next cycle
// - after reset: first differential pair, ratio 256, normal rate
// - enable bit low keeps the previous speed and channel
// - host presents input bits during output; shifted in by serial clock
// - first conversion after new selection is valid, nothing discarded
// - frequency control tied to a rail uses internal oscillator, else external
// - chip select low enables serial output and wakes from sleep
// - after each conversion sleep while chip select stays high
// - chip select rising during output aborts and starts a new conversion
// - chip select high keeps serial output high impedance
// - in conversion and sleep serial output shows status: high converting
// - out-of-range inputs give distinct overrange and underrange codes
// - output ends after 32 bits or chip select rise, then converts again
// - serial output changes on falling serial clock edge
// - serial input is sampled on rising serial clock edge
module adcsc_top
	import adcsc_pkg::*;
#(
	parameter int CONV_TICKS_PER_OSR = 40,
	parameter int CONV_BASE_TICKS    = 178
)(
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	input  wire logic        cs_n_in,
	input  wire logic        sck_in,
	input  wire logic        sdi_in,
	input  wire logic        clock_source_select_in,
	input  wire logic        frequency_control_in,
	input  wire logic [23:0] result_in,
	input  wire logic [4:0]  sub_lsb_in,
	input  wire logic        sign_in,
	input  wire logic        overrange_in,
	input  wire logic        underrange_in,
	output logic             sck_out,
	output logic             sck_oe_n_out,
	output logic             sdo_out,
	output logic             sdo_oe_n_out,
	output logic             busy_out,
	output logic [1:0]       channel_out,
	output logic [3:0]       oversampling_ratio_out,
	output logic             double_rate_mode_out
);

	// ==========================================================
	// conversion length in oscillator ticks for a ratio code
	function automatic logic [31:0] conv_ticks(input logic [3:0] code, input logic dbl);
		logic [5:0]  sh;
		logic [31:0] oversampling_ratio;
		logic [31:0] body;
		sh   = OSR_MIN_LOG2 + {2'h0, code};
		oversampling_ratio  = 32'h00000001 << sh;
		body = oversampling_ratio * 32'(CONV_TICKS_PER_OSR);
		if (dbl)
			body = body >> 1;
		conv_ticks = body + 32'(CONV_BASE_TICKS);
	endfunction

	// ==========================================================
	// pin synchronisers
	logic [1:0] cs_sync_reg;
	logic [1:0] sck_sync_reg;
	logic [1:0] sdi_sync_reg;
	logic [1:0] ext_sync_reg;
	logic [1:0] f0_sync_reg;
	logic       sck_last_reg;
	logic       f0_last_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cs_sync_reg  <= 2'h3;
			sck_sync_reg <= 2'h0;
			sdi_sync_reg <= 2'h0;
			ext_sync_reg <= 2'h0;
			f0_sync_reg  <= 2'h0;
			sck_last_reg <= 1'b0;
			f0_last_reg  <= 1'b0;
		end
		else
		begin
			cs_sync_reg  <= {cs_sync_reg[0], cs_n_in};
			sck_sync_reg <= {sck_sync_reg[0], sck_in};
			sdi_sync_reg <= {sdi_sync_reg[0], sdi_in};
			ext_sync_reg <= {ext_sync_reg[0], clock_source_select_in};
			f0_sync_reg  <= {f0_sync_reg[0], frequency_control_in};
			sck_last_reg <= sck_sync_reg[1];
			f0_last_reg  <= f0_sync_reg[1];
		end
	end

	logic cs_n;
	logic int_mode;
	assign cs_n     = cs_sync_reg[1];
	assign int_mode = ext_sync_reg[1];

	// ==========================================================
	// conversion clock: internal divider or edges on frequency control
	logic [7:0] f0_idle_reg;
	logic [7:0] osc_div_reg;
	logic       f0_rise;
	logic       f0_ext;
	logic       conv_tick;

	assign f0_rise   = f0_sync_reg[1] & ~f0_last_reg;
	assign f0_ext    = (f0_idle_reg != 8'h00);
	assign conv_tick = f0_ext ? f0_rise : (osc_div_reg == 8'h00);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			f0_idle_reg <= 8'h00;
		else if (f0_sync_reg[1] != f0_last_reg)
			f0_idle_reg <= 8'(FREQ_IDLE);
		else if (f0_idle_reg != 8'h00)
			f0_idle_reg <= f0_idle_reg - 8'h01;
	end

	// the divider runs free; a steady level on the pin reads as tied, so its ticks drive the conversion
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			osc_div_reg <= 8'h00;
		else if (osc_div_reg == 8'h00)
			osc_div_reg <= 8'(OSC_DIV - 1);
		else
			osc_div_reg <= osc_div_reg - 8'h01;
	end

	// ==========================================================
	// internal serial clock, idle low, runs only in data output
	adcsc_state_t state_reg;
	logic [7:0]   isck_cnt_reg;
	logic         isck_reg;
	logic         isck_run;

	assign isck_run = (state_reg == ST_OUTPUT) && int_mode && !cs_n ? 1'b1 : 1'b0;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			isck_cnt_reg <= 8'h00;
			isck_reg     <= 1'b0;
		end
		else if (!isck_run)
		begin
			isck_cnt_reg <= 8'h00;
			isck_reg     <= 1'b0;
		end
		else if (isck_cnt_reg == 8'(ISCK_HALF - 1))
		begin
			isck_cnt_reg <= 8'h00;
			isck_reg     <= ~isck_reg;
		end
		else
			isck_cnt_reg <= isck_cnt_reg + 8'h01;
	end

	// edges of whichever serial clock is in charge
	logic sck_rise;
	logic sck_fall;
	logic isck_edge;

	assign isck_edge = isck_run && (isck_cnt_reg == 8'(ISCK_HALF - 1));
	assign sck_rise  = int_mode ? (isck_edge & ~isck_reg)
		: (sck_sync_reg[1] & ~sck_last_reg);
	assign sck_fall  = int_mode ? (isck_edge & isck_reg)
		: (~sck_sync_reg[1] & sck_last_reg);

	// ==========================================================
	// conversion cycle
	logic [31:0] conv_cnt_reg;
	logic [5:0]  bit_cnt_reg;
	logic        conv_done;
	logic        out_end;

	assign conv_done = (conv_cnt_reg == 32'h00000000);
	// 32 rising edges read the whole word
	assign out_end   = cs_n || (sck_rise && bit_cnt_reg == WORD_BITS_6 - 6'h01);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			state_reg <= ST_CONV;
		else
		begin
			case (state_reg)
				ST_CONV:
				begin
					if (conv_tick && conv_done)
						state_reg <= ST_SLEEP;
				end
				ST_SLEEP:
				begin
					if (!cs_n)
						state_reg <= ST_OUTPUT;
				end
				ST_OUTPUT:
				begin
					if (out_end)
						state_reg <= ST_CONV;
				end
				default:
					state_reg <= ST_CONV;
			endcase
		end
	end

	// ==========================================================
	// selection for the running conversion, taken from the input word
	logic [7:0] cfg_shift_reg;
	logic [1:0] ch_reg;
	logic [3:0] osr_reg;
	logic       dbl_reg;
	logic       cfg_full;
	logic [3:0] osr_next;

	assign cfg_full = (bit_cnt_reg >= CFG_BITS_6);
	assign osr_next = (cfg_shift_reg[CFG_OSR_HI:CFG_OSR_LO] > OSR_CODE_MAX)
		? OSR_CODE_MAX : cfg_shift_reg[CFG_OSR_HI:CFG_OSR_LO];

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			cfg_shift_reg <= 8'h00;
		else if (state_reg == ST_SLEEP)
			cfg_shift_reg <= 8'h00;
		else if (state_reg == ST_OUTPUT && sck_rise && !cfg_full)
			cfg_shift_reg <= {cfg_shift_reg[6:0], sdi_sync_reg[1]};
	end

	// a selection applies from the very next conversion with no discard
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			ch_reg  <= CH_RESET;
			osr_reg <= OSR_RESET;
			dbl_reg <= DBL_RESET;
		end
		else if (state_reg == ST_OUTPUT && out_end && cfg_full
			&& cfg_shift_reg[CFG_EN_POS])
		begin
			ch_reg  <= cfg_shift_reg[CFG_CH_HI:CFG_CH_LO];
			osr_reg <= osr_next;
			dbl_reg <= cfg_shift_reg[CFG_DBL_POS];
		end
	end

	// ==========================================================
	// conversion length counter, loaded as the selection takes effect
	logic [31:0] conv_load;
	assign conv_load = (cfg_full && cfg_shift_reg[CFG_EN_POS])
		? conv_ticks(osr_next, cfg_shift_reg[CFG_DBL_POS])
		: conv_ticks(osr_reg, dbl_reg);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			conv_cnt_reg <= 32'(CONV_TICKS_PER_OSR * 256 + CONV_BASE_TICKS);
		else if (state_reg == ST_OUTPUT && out_end)
			conv_cnt_reg <= conv_load;
		else if (state_reg == ST_CONV && conv_tick && !conv_done)
			conv_cnt_reg <= conv_cnt_reg - 32'h00000001;
	end

	// ==========================================================
	// result word and output shifter
	logic [31:0] result_reg;
	logic [31:0] shift_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
			result_reg <= 32'h00000000;
		else if (state_reg == ST_CONV && conv_tick && conv_done)
		begin
			if (overrange_in)
				result_reg <= {2'h0, OVER_CODE};
			else if (underrange_in)
				result_reg <= {2'h0, UNDER_CODE};
			else
				result_reg <= {2'h0, sign_in, result_in, sub_lsb_in};
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			shift_reg   <= 32'h00000000;
			bit_cnt_reg <= 6'h00;
		end
		else if (state_reg == ST_SLEEP)
		begin
			shift_reg   <= result_reg;
			bit_cnt_reg <= 6'h00;
		end
		else if (state_reg == ST_OUTPUT)
		begin
			if (sck_rise)
				bit_cnt_reg <= bit_cnt_reg + 6'h01;
			// the first bit is out before any clock, later ones move on falls
			if (sck_fall && bit_cnt_reg != 6'h00)
				shift_reg <= {shift_reg[30:0], 1'b0};
		end
	end

	// ==========================================================
	// pin outputs, all registered; sck_out keeps step with the state so busy frames every rise
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			busy_out     <= 1'b1;
			sdo_out      <= 1'b1;
			sdo_oe_n_out <= 1'b1;
			sck_out      <= 1'b0;
			sck_oe_n_out <= 1'b1;
		end
		else
		begin
			busy_out     <= (state_reg == ST_CONV);
			sdo_oe_n_out <= cs_n;
			if (state_reg == ST_OUTPUT)
				sdo_out <= shift_reg[31];
			else
				sdo_out <= (state_reg == ST_CONV);
			sck_out      <= isck_run && (isck_edge ? ~isck_reg : isck_reg);
			sck_oe_n_out <= ~(int_mode && state_reg == ST_OUTPUT);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			channel_out            <= CH_RESET;
			oversampling_ratio_out <= OSR_RESET;
			double_rate_mode_out   <= DBL_RESET;
		end
		else
		begin
			channel_out            <= ch_reg;
			oversampling_ratio_out <= osr_reg;
			double_rate_mode_out   <= dbl_reg;
		end
	end

endmodule

// [test/adcsc_top_properties.sv]
/*
 * adcsc_props: concurrent checks on the ports of adcsc_top, bound below.
 * assumes clock select changes only while no frame is running.
 */
module adcsc_props
	import adcsc_pkg::*;
#(
	parameter int CONV_TICKS_PER_OSR = 40,
	parameter int CONV_BASE_TICKS    = 178
)(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       cs_n_in,
	input wire logic       clock_source_select_in,
	input wire logic       sck_out,
	input wire logic       sck_oe_n_out,
	input wire logic       sdo_out,
	input wire logic       sdo_oe_n_out,
	input wire logic       busy_out,
	input wire logic [1:0] channel_out,
	input wire logic [3:0] oversampling_ratio_out,
	input wire logic       double_rate_mode_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// ==========================================================
	// serial port
	serial_clk_own_a: assert property (!sck_oe_n_out |->
		!busy_out && clock_source_select_in)
		else $error("serial clock driven outside internal data output");
	tri_state_a: assert property (cs_n_in[*5] |-> sdo_oe_n_out)
		else $error("serial output driven with chip select high");
	driver_on_a: assert property (!cs_n_in[*5] |-> !sdo_oe_n_out)
		else $error("serial output not driven with chip select low");
	status_high_a: assert property (busy_out && $past(busy_out) && !sdo_oe_n_out |-> sdo_out)
		else $error("status low while converting");
	frame_busy_a: assert property ($rose(sck_out) |-> !busy_out)
		else $error("serial clock outside the low busy frame");
	// ==========================================================
	// conversion cycle
	// sync lag of chip select is at most four cycles, so eight give margin
	sleep_hold_a: assert property (cs_n_in[*8] ##0 !busy_out |=> !busy_out)
		else $error("left sleep with chip select high");
	abort_conv_a: assert property ($rose(cs_n_in) && !busy_out |-> ##[1:8] busy_out)
		else $error("no new conversion after abort");
	reset_sel_a: assert property ($fell(rst_in) |-> channel_out == CH_RESET
		&& oversampling_ratio_out == OSR_RESET && !double_rate_mode_out)
		else $error("selection after reset wrong");
	cover property (cs_n_in[*8] ##0 !busy_out);
	cover property ($rose(cs_n_in) && !busy_out);
	cover property ($rose(sck_out));
endmodule
bind adcsc_top adcsc_props #(
	.CONV_TICKS_PER_OSR(CONV_TICKS_PER_OSR),
	.CONV_BASE_TICKS   (CONV_BASE_TICKS)
) i_props (.clk_in, .rst_in, .cs_n_in, .clock_source_select_in, .sck_out, .sck_oe_n_out,
	.sdo_out, .sdo_oe_n_out, .busy_out, .channel_out, .oversampling_ratio_out,
	.double_rate_mode_out);

// [test/adcsc_host_model.sv]
/*
 * adcsc_host_model: host on the far side of the serial port.
 * assumes the bench resolves the shared serial clock pin into sck_pin_in.
 */
module adcsc_host_model
	import adcsc_pkg::*;
(
	input  wire logic clk_in,
	input  wire logic busy_in,
	input  wire logic sdo_in,
	input  wire logic sck_pin_in,
	input  wire logic internal_in,
	output logic      cs_n_out,
	output logic      sck_out,
	output logic      sdi_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0] rx_word;
	event        done;
	initial
	begin
		cs_n_out = 1'b1;
		sck_out  = 1'b0;
		sdi_out  = 1'b0;
	end
	// ==========================================================
	// one frame; nbits below 32 aborts by raising chip select early
	task automatic frame(input logic [7:0] cfg, input int nbits, input int gap);
		int i;
		rx_word = '0;
		repeat (gap) @(posedge clk_in);
		#1 cs_n_out = 1'b0;
		for (i = 0; i < 2000 && busy_in !== 1'b0; i++) @(posedge clk_in);
		repeat (8) @(posedge clk_in);
		#1;
		for (i = 0; i < nbits; i++)
		begin
			// past the word the line toggles so stale bits never look valid
			sdi_out = (i < CFG_BITS) ? cfg[7 - i] : ~sdi_out;
			if (internal_in)
			begin
				@(posedge sck_pin_in);
				rx_word = {rx_word[30:0], sdo_in};
				@(negedge sck_pin_in);
			end
			else
			begin
				#80 sck_out = 1'b1;
				#78 rx_word = {rx_word[30:0], sdo_in};
				#2 sck_out = 1'b0;
			end
		end
		repeat (5) @(posedge clk_in);
		#1 cs_n_out = 1'b1;
		sdi_out = ~sdi_out;
		-> done;
		repeat (8) @(posedge clk_in);
	endtask
endmodule

// [test/testbench.sv]
/*
 * testbench: drives adcsc_top through the host model and checks words and selection.
 * assumes short conversion parameters and a 50 MHz system clock.
 */
`define CHECK(got, exp, msg) \
	begin \
		tests_run++; \
		if ((got) !== (exp)) \
		begin \
			errors++; \
			$display("unexpected %0t %s", $time, msg); \
		end \
	end
module testbench
	import adcsc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk_in, rst_in, cs_n_in, sck_host, sdi_in, fc_run;
	logic        clock_source_select_in, frequency_control_in;
	logic [23:0] result_in;
	logic [4:0]  sub_lsb_in;
	logic        sign_in, overrange_in, underrange_in;
	logic        sck_out, sck_oe_n_out, sdo_out, sdo_oe_n_out, busy_out;
	logic [1:0]  channel_out;
	logic [3:0]  oversampling_ratio_out;
	logic        double_rate_mode_out;
	wire logic   sck_in;
	wire logic   sdo_pin;
	wire logic [6:0] sel_now;
	int          errors = 0;
	int          tests_run = 0;
	logic [31:0] rng = 32'hBEF1;
	logic [31:0] word_q[$];
	logic [6:0]  sel_q[$];
	// the pin carries whoever drives it; the host idles low in internal mode
	assign sck_in = sck_oe_n_out ? sck_host : sck_out;
	// a released data line reads inverted so a stale bit can never pass
	assign sdo_pin = sdo_oe_n_out ? ~sdo_out : sdo_out;
	assign sel_now = {channel_out, oversampling_ratio_out, double_rate_mode_out};
	adcsc_top #(.CONV_TICKS_PER_OSR(1), .CONV_BASE_TICKS(20)) i_dut (.clk_in, .rst_in,
		.cs_n_in, .sck_in, .sdi_in, .clock_source_select_in, .frequency_control_in,
		.result_in, .sub_lsb_in, .sign_in, .overrange_in, .underrange_in, .sck_out,
		.sck_oe_n_out, .sdo_out, .sdo_oe_n_out, .busy_out, .channel_out,
		.oversampling_ratio_out, .double_rate_mode_out);
	adcsc_host_model i_host (.clk_in, .busy_in(busy_out), .sdo_in(sdo_pin),
		.sck_pin_in(sck_in), .internal_in(clock_source_select_in), .cs_n_out(cs_n_in),
		.sck_out(sck_host), .sdi_out(sdi_in));
	function automatic logic [31:0] rnd_next();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	task automatic end_of_test();
		if (errors == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ==========================================================
	// clock, watchdog and external conversion clock
	initial
	begin
		clk_in = 1'b0;
		forever #10 clk_in = ~clk_in;
	end
	initial
	begin
		repeat (40000) @(posedge clk_in);
		errors++;
		$display("unexpected %0t watchdog expired", $time);
		end_of_test();
	end
	always @(posedge clk_in)
		if (fc_run)
			frequency_control_in <= #1 ~frequency_control_in;
	// ==========================================================
	// result monitor
	initial
	begin
		logic [31:0] got;
		forever
		begin
			@(i_host.done);
			got = i_host.rx_word;
			repeat (10) @(posedge clk_in);
			`CHECK(got, word_q.pop_front(), "data word")
			`CHECK(sel_now, sel_q.pop_front(), "selection")
		end
	end
	// ==========================================================
	// stimulus: both clock modes, range codes, disable, aborts, sleep
	initial
	begin
		int          k;
		int          nbits;
		logic [7:0]  cfg;
		logic [31:0] full;
		logic [6:0]  sel_exp;
		{rst_in, fc_run, clock_source_select_in, frequency_control_in} = 4'h8;
		{result_in, sub_lsb_in, sign_in, overrange_in, underrange_in} = '0;
		repeat (4) @(posedge clk_in);
		#1 rst_in = 1'b0;
		sel_exp = {CH_RESET, OSR_RESET, DBL_RESET};
		`CHECK(sel_now, sel_exp, "reset selection")
		for (k = 0; k < 8; k++)
		begin
			@(posedge clk_in);
			#1 full = rnd_next();
			{sign_in, sub_lsb_in, result_in} = full[29:0];
			overrange_in = (k == 2);
			underrange_in = (k == 3);
			clock_source_select_in = k[0];
			fc_run = (k == 7);
			// ratio codes kept small so conversions stay short
			cfg = {k != 4, full[31:30], 2'b00, full[1:0], full[2]};
			nbits = (k == 5) ? 12 : (k == 6) ? 5 : WORD_BITS;
			if (overrange_in)
				full = {2'b00, OVER_CODE};
			else if (underrange_in)
				full = {2'b00, UNDER_CODE};
			else
				full = {2'b00, sign_in, result_in, sub_lsb_in};
			word_q.push_back(full >> (WORD_BITS - nbits));
			if (nbits >= CFG_BITS && cfg[CFG_EN_POS])
				sel_exp = cfg[6:0];
			sel_q.push_back(sel_exp);
			// a long gap lets the conversion finish with chip select high, so it sleeps
			i_host.frame(cfg, nbits, (k == 3) ? 1500 : 4);
		end
		repeat (20) @(posedge clk_in);
		end_of_test();
	end
endmodule
